/* rtd_pkg.sv */
/*
 * Shared constants and types for the ring trip detector: direct and
 * indirect register addresses, field positions, reset values, linefeed
 * codes and timing constants.
 * Assumes a single 50 MHz system clock and an 8-bit direct register port.
 */
package rtd_pkg;

    // System clock rate, used to turn times into cycle counts.
    localparam int CLK_MHZ = 50;

    // Direct register addresses.
    localparam logic [6:0] ADDR_IRQ_PEND    = 7'h13;
    localparam logic [6:0] ADDR_IRQ_EN      = 7'h16;
    localparam logic [6:0] ADDR_IND_DATA_LO = 7'h1c;
    localparam logic [6:0] ADDR_IND_DATA_HI = 7'h1d;
    localparam logic [6:0] ADDR_IND_WRITE   = 7'h1e;
    localparam logic [6:0] ADDR_IND_READ    = 7'h1f;
    localparam logic [6:0] ADDR_LINEFEED    = 7'h40;
    localparam logic [6:0] ADDR_TRIP_STAT   = 7'h44;
    localparam logic [6:0] ADDR_DEBOUNCE    = 7'h46;
    localparam logic [6:0] ADDR_HIGH_BATTERY_LEVEL       = 7'h4a;
    localparam logic [6:0] ADDR_LOOP_CUR    = 7'h4f;
    localparam logic [6:0] ADDR_ILIM        = 7'h6c;

    // Indirect register indices.
    localparam logic [7:0] IND_THRESHOLD = 8'h10;
    localparam logic [7:0] IND_FILT_COEF = 8'h17;
    localparam logic [7:0] IND_HEADROOM  = 8'h1b;

    // Field positions and widths.
    localparam int TRIP_BIT    = 0;
    localparam int BOOST_BIT   = 7;
    localparam int COEF_W      = 13;
    localparam int THR_W       = 6;
    localparam int DEB_W       = 7;
    localparam int VBAT_W      = 6;
    localparam int HEAD_W      = 4;
    localparam int LF_W        = 3;
    localparam int FILT_W      = 16;

    // Linefeed codes.
    localparam logic [2:0] LF_OPEN    = 3'h0;
    localparam logic [2:0] LF_RINGING = 3'h4;

    // Reset values.
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // Current limit boost length after ringing ends.
    localparam int BOOST_TIME_US = 1000;
    localparam int BOOST_CYCLES  = BOOST_TIME_US * CLK_MHZ;

    // One direct register access from the control port.
    typedef struct packed
    {
        logic [6:0] addr;
        logic [7:0] wrData;
        logic       wrEn;
        logic       rdEn;
    } rtd_regreq_t;

    // Current limit boost sequencer states.
    typedef enum logic [1:0]
    {
        BST_IDLE = 2'b00,
        BST_RUN  = 2'b01
    } rtd_boost_t;

endpackage

/* rtd_debounce.sv */
/*
 * Debouncer for the ring trip comparator: the output changes only after
 * the input has held the opposite level for a whole programmed interval.
 * Assumes sampleEn is a one-cycle pulse on sys_clk and interval counts
 * samples; clear returns the output to the inactive level.
 */
module rtd_debounce
(
    input  wire logic                      sys_clk,
    input  wire logic                      rst_n,
    input  wire logic                      clear,
    input  wire logic                      sampleEn,
    input  wire logic                      rawIn,
    input  wire logic [rtd_pkg::DEB_W-1:0] interval,
    output logic                           level,
    output logic                           rise
);
    import rtd_pkg::*;

    logic [DEB_W-1:0] cnt_ff;
    logic [DEB_W-1:0] nxt_cnt;
    logic             level_ff;
    logic             rise_ff;
    wire              differs = rawIn != level_ff;
    wire  [DEB_W-1:0] cntInc  = cnt_ff + 1'b1;
    // An interval of zero lets a single opposite sample through.
    wire              expired = differs && (cntInc >= interval);
    wire              flip    = sampleEn && expired;

    // Count consecutive opposite samples; any agreeing sample restarts it.
    assign nxt_cnt = (!differs || flip) ? '0 : (sampleEn ? cntInc : cnt_ff);

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || clear)
        begin
            cnt_ff   <= '0;
            level_ff <= 1'b0;
            rise_ff  <= 1'b0;
        end
        else
        begin
            cnt_ff   <= nxt_cnt;              // R4
            level_ff <= flip ? ~level_ff : level_ff;
            rise_ff  <= flip && !level_ff;
        end
    end

    assign level = level_ff;
    assign rise  = rise_ff;

    // The output may only move once the opposite level has run its course.
    property level_move_p;
        @(posedge sys_clk) disable iff (!rst_n)
        (!clear && $changed(level_ff)) |-> $past(sampleEn) && $past(expired);
    endproperty
    debounce_hold_a: assert property (level_move_p) // R4
        else $error("Debounced level changed before the interval ran out.");

endmodule

/* rtd_detector.sv */
/*
 * Ring trip detector with the ringing common-mode and current limit
 * controls: direct and indirect registers, loop current low-pass filter,
 * threshold compare, debounce, status and interrupt pending logic.
 * Assumes loop current samples and register strobes come from logic on
 * sys_clk; reads answer one cycle after the read strobe.
 */
// Notes on behaviour
// (R1) Loop current samples are used for trip detection only in the ringing linefeed state.
// (R2) Samples pass through a one-pole low-pass filter with a 13-bit coefficient.
// (R3) The filter output is compared with a 6-bit threshold and fed to a debouncer.
// (R4) The debounced output changes only after a full interval of the opposite level.
// (R5) A satisfied debounce sets the ring trip detected status bit.
// (R6) A ring trip interrupt is raised only while its enable bit is set.
// (R7) A pending ring trip interrupt is held in its own bit of a status register.
// (R8) The trip detected status is read only; writes leave it untouched.
// (R9) During ringing the common-mode level is half of battery minus headroom.
// (R10) The ringing headroom is a 4-bit indirect field at 1.5 V per step.
// (R11) With the boost bit set the current limit is raised briefly after ringing ends; the code boosts only when ringing ends into a non-open state.
// (R12) Software picks coefficient, threshold and interval to suit the ringing frequency.
// (R13) Software keeps the battery setting above the peak ringing voltage.
// (R14) Writing 100 binary to the linefeed field enters the ringing state.
// (R15) The pending bit stays set until software clears it.
module rtd_detector
#(
    parameter int BOOST_LEN = rtd_pkg::BOOST_CYCLES
)
(
    input  wire logic                 sys_clk,
    input  wire logic                 rst_n,
    input  wire rtd_pkg::rtd_regreq_t regReq,
    input  wire logic [7:0]           loopCurrent,
    input  wire logic                 loopValid,
    output logic [7:0]                regRdData,
    output logic                      tripIrq,
    output logic [6:0]                ringCmLevel,
    output logic                      ringingActive,
    output logic                      currentBoost
);
    import rtd_pkg::*;

    // Direct registers.
    logic [LF_W-1:0]   linefeed_ff;
    logic              irqEnable_ff;
    logic              irqPending_ff;
    logic [DEB_W-1:0]  debounce_ff;
    logic [VBAT_W-1:0] high_battery_level_ff;
    logic              boostEn_ff;
    logic [7:0]        loopCur_ff;
    logic [15:0]       indData_ff;
    // Indirect registers.
    logic [THR_W-1:0]  threshold_ff;
    logic [COEF_W-1:0] coef_ff;
    logic [HEAD_W-1:0] headroom_ff;
    // Datapath and outputs.
    logic [FILT_W-1:0] filt_ff;
    logic [FILT_W-1:0] nxt_filt;
    logic [7:0]        regRdData_ff;
    logic [6:0]        cmLevel_ff;
    logic              ringing_ff;
    logic              tripIrq_ff;
    logic              boost_ff;
    rtd_boost_t        bstState_ff;
    logic [31:0]       bstCnt_ff;
    logic              tripLevel;
    logic              tripRise;

    // Address decode.
    wire wrStb   = regReq.wrEn;
    wire wrPend  = wrStb && (regReq.addr == ADDR_IRQ_PEND);
    wire wrEnab  = wrStb && (regReq.addr == ADDR_IRQ_EN);
    wire wrLo    = wrStb && (regReq.addr == ADDR_IND_DATA_LO);
    wire wrHi    = wrStb && (regReq.addr == ADDR_IND_DATA_HI);
    wire wrInd   = wrStb && (regReq.addr == ADDR_IND_WRITE);
    wire rdInd   = wrStb && (regReq.addr == ADDR_IND_READ);
    wire wrLf    = wrStb && (regReq.addr == ADDR_LINEFEED);
    wire wrDeb   = wrStb && (regReq.addr == ADDR_DEBOUNCE);
    wire wrVbat  = wrStb && (regReq.addr == ADDR_HIGH_BATTERY_LEVEL);
    wire wrIlim  = wrStb && (regReq.addr == ADDR_ILIM);
    wire [7:0] indIdx = regReq.wrData;

    wire ringing  = linefeed_ff == LF_RINGING;   // R14
    wire sampleEn = loopValid && ringing;        // R1
    // Ringing has ended into a powered (non-open) dc feed state.
    wire leaveRing = ringing && wrLf && (regReq.wrData[LF_W-1:0] != LF_RINGING)
                     && (regReq.wrData[LF_W-1:0] != LF_OPEN);

    // One-pole low-pass: y += (x - y) * coef / 2^13, x scaled to 8.8 format.
    wire signed [16:0] filtDiff = $signed({1'b0, loopCurrent, 8'h00})
                                  - $signed({1'b0, filt_ff});
    wire signed [30:0] filtProd = filtDiff * $signed({1'b0, coef_ff});
    wire signed [30:0] filtStep = filtProd >>> COEF_W;
    wire        [16:0] filtSum  = {1'b0, filt_ff} + filtStep[16:0];
    assign nxt_filt = sampleEn ? filtSum[FILT_W-1:0] : filt_ff;   // R2

    // Integer part of the filtered current against the threshold.
    wire tripRaw = filt_ff[FILT_W-1:8] > {{(8-THR_W){1'b0}}, threshold_ff};   // R3

    // Common-mode level in half-steps of 1.5 V, clamped at zero.
    wire [6:0] cmDiff  = {1'b0, high_battery_level_ff} - {3'b000, headroom_ff};
    wire [6:0] cmLevel = (high_battery_level_ff > {2'b00, headroom_ff}) ? cmDiff : 7'h00;

    // Read multiplexer; unmapped addresses read as zero.
    wire [7:0] rdMux =
        (regReq.addr == ADDR_IRQ_PEND)    ? {7'h00, irqPending_ff} :
        (regReq.addr == ADDR_IRQ_EN)      ? {7'h00, irqEnable_ff} :
        (regReq.addr == ADDR_IND_DATA_LO) ? indData_ff[7:0] :
        (regReq.addr == ADDR_IND_DATA_HI) ? indData_ff[15:8] :
        (regReq.addr == ADDR_LINEFEED)    ? {5'h00, linefeed_ff} :
        (regReq.addr == ADDR_TRIP_STAT)   ? {7'h00, tripLevel} :   // R5 R8
        (regReq.addr == ADDR_DEBOUNCE)    ? {1'b0, debounce_ff} :
        (regReq.addr == ADDR_HIGH_BATTERY_LEVEL)       ? {2'b00, high_battery_level_ff} :
        (regReq.addr == ADDR_LOOP_CUR)    ? loopCur_ff :
        (regReq.addr == ADDR_ILIM)        ? {boostEn_ff, 7'h00} : RST_BYTE;

    // Indirect read value selected by the index written to the read port.
    wire [15:0] indRdMux =
        (indIdx == IND_THRESHOLD) ? {10'h000, threshold_ff} :
        (indIdx == IND_FILT_COEF) ? {3'b000, coef_ff} :
        (indIdx == IND_HEADROOM)  ? {12'h000, headroom_ff} : RST_WORD;

    rtd_debounce u_debounce
    (
        .sys_clk  (sys_clk),
        .rst_n    (rst_n),
        .clear    (!ringing),
        .sampleEn (sampleEn),
        .rawIn    (tripRaw),
        .interval (debounce_ff),
        .level    (tripLevel),
        .rise     (tripRise)
    );

    // Direct register writes; the trip status has no write path at all.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            linefeed_ff  <= LF_OPEN;
            irqEnable_ff <= 1'b0;
            debounce_ff  <= '0;
            high_battery_level_ff     <= '0;
            boostEn_ff   <= 1'b0;
        end
        else
        begin
            if (wrLf)   linefeed_ff  <= regReq.wrData[LF_W-1:0];    // R14
            if (wrEnab) irqEnable_ff <= regReq.wrData[TRIP_BIT];    // R6
            if (wrDeb)  debounce_ff  <= regReq.wrData[DEB_W-1:0];
            if (wrVbat) high_battery_level_ff     <= regReq.wrData[VBAT_W-1:0];
            if (wrIlim) boostEn_ff   <= regReq.wrData[BOOST_BIT];   // R11
        end
    end

    // Indirect data window and indirect registers.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            indData_ff   <= RST_WORD;
            threshold_ff <= '0;
            coef_ff      <= '0;
            headroom_ff  <= '0;
        end
        else
        begin
            if (wrLo)  indData_ff[7:0]  <= regReq.wrData;
            if (wrHi)  indData_ff[15:8] <= regReq.wrData;
            if (rdInd) indData_ff       <= indRdMux;
            if (wrInd && indIdx == IND_THRESHOLD) threshold_ff <= indData_ff[THR_W-1:0];
            if (wrInd && indIdx == IND_FILT_COEF) coef_ff <= indData_ff[COEF_W-1:0];
            if (wrInd && indIdx == IND_HEADROOM)  headroom_ff <= indData_ff[HEAD_W-1:0]; // R10
        end
    end

    // Filter state, sample capture and pending flag; a new trip beats a clear.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n || !ringing)
        begin
            filt_ff <= RST_WORD;
        end
        else
        begin
            filt_ff <= nxt_filt;
        end
        if (!rst_n)
        begin
            loopCur_ff    <= RST_BYTE;
            irqPending_ff <= 1'b0;
            regRdData_ff  <= RST_BYTE;
            tripIrq_ff    <= 1'b0;
        end
        else
        begin
            if (loopValid) loopCur_ff <= loopCurrent;
            if (tripRise && irqEnable_ff)
                irqPending_ff <= 1'b1;                             // R7
            else if (wrPend && regReq.wrData[TRIP_BIT])
                irqPending_ff <= 1'b0;                             // R15
            if (regReq.rdEn) regRdData_ff <= rdMux;                // R5
            tripIrq_ff <= irqPending_ff && irqEnable_ff;           // R6
        end
    end

    // Common-mode level and ringing indication.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cmLevel_ff <= 7'h00;
            ringing_ff <= 1'b0;
        end
        else
        begin
            if (ringing) cmLevel_ff <= cmLevel;                    // R9
            ringing_ff <= ringing;
        end
    end

    // Boost sequencer: a fixed-length current limit raise after ringing.
    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            bstState_ff <= BST_IDLE;
            bstCnt_ff   <= '0;
            boost_ff    <= 1'b0;
        end
        else
        begin
            case (bstState_ff)
                BST_IDLE:
                begin
                    bstCnt_ff <= '0;
                    if (leaveRing && boostEn_ff)                   // R11
                    begin
                        bstState_ff <= BST_RUN;
                        boost_ff    <= 1'b1;
                    end
                end
                BST_RUN:
                begin
                    bstCnt_ff <= bstCnt_ff + 1'b1;
                    if (bstCnt_ff == 32'(BOOST_LEN - 1))
                    begin
                        bstState_ff <= BST_IDLE;
                        boost_ff    <= 1'b0;
                    end
                end
                default:
                begin
                    bstState_ff <= BST_IDLE;
                    boost_ff    <= 1'b0;
                end
            endcase
        end
    end

    assign regRdData     = regRdData_ff;
    assign tripIrq       = tripIrq_ff;
    assign ringCmLevel   = cmLevel_ff;
    assign ringingActive = ringing_ff;
    assign currentBoost  = boost_ff;

    // Checks on the guarded behaviour.
    sequence leave_ring_s;
        leaveRing && boostEn_ff && bstState_ff == BST_IDLE;
    endsequence

    idle_no_trip_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
        !ringing |=> !tripLevel && filt_ff == RST_WORD)
        else $error("Trip state moved outside ringing.");
    filter_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R2
        ringing && !loopValid ##1 ringing |-> $stable(filt_ff))
        else $error("Filter moved without a sample.");
    status_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
        regReq.rdEn && regReq.addr == ADDR_TRIP_STAT |=> regRdData[TRIP_BIT] == $past(tripLevel))
        else $error("Trip status read back wrong.");
    pend_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
        tripRise && irqEnable_ff |=> irqPending_ff ##1 tripIrq)
        else $error("Enabled trip did not become pending.");
    no_enable_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
        !irqEnable_ff && !irqPending_ff |=> !irqPending_ff)
        else $error("Pending set while disabled.");
    pend_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
        irqPending_ff && !(wrPend && regReq.wrData[TRIP_BIT]) |=> irqPending_ff)
        else $error("Pending bit dropped without a clear.");
    status_ro_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
        ringing && !sampleEn && wrStb && regReq.addr == ADDR_TRIP_STAT |=> $stable(tripLevel))
        else $error("Write altered the trip status.");
    cm_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
        ringing && high_battery_level_ff > {2'b00, headroom_ff} |=>
        ringCmLevel == 7'($past(high_battery_level_ff)) - 7'($past(headroom_ff)))
        else $error("Common-mode level wrong during ringing.");
    boost_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
        leave_ring_s |=> currentBoost [*8])
        else $error("Current boost missing after ringing.");

endmodule

/* tb_top.sv */
/*
 * Self-checking bench for the ring trip detector: register tasks on the
 * direct port, indirect access through the data window, loop samples.
 * Assumes read data is registered on the edge that takes the read strobe.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtd_pkg::*;

    // Boost shortened so the count can be watched cycle by cycle.
    localparam int BOOST_SIM = 20;

    logic        sys_clk       = 1'b0;
    logic        rst_n         = 1'b0;
    rtd_regreq_t req           = '0;
    logic [7:0]  loopCurrent   = 8'h00;
    logic        loopValid     = 1'b0;
    logic [7:0]  regRdData;
    logic        tripIrq;
    logic [6:0]  ringCmLevel;
    logic        ringingActive;
    logic        currentBoost;
    int          badCount      = 0;
    int          numChecks     = 0;
    logic [15:0] word;
    int          boostCnt;
    logic [6:0]  rstAddr [9]   = '{ADDR_IRQ_PEND, ADDR_IRQ_EN, ADDR_TRIP_STAT, ADDR_DEBOUNCE,
                                    ADDR_HIGH_BATTERY_LEVEL, ADDR_LOOP_CUR, ADDR_ILIM, ADDR_LINEFEED, 7'h7f};

    // Free-running 50 MHz clock.
    always #10ns sys_clk = ~sys_clk;

    rtd_detector #(.BOOST_LEN(BOOST_SIM)) i_dut
    (
        .sys_clk       (sys_clk),
        .rst_n         (rst_n),
        .regReq        (req),
        .loopCurrent   (loopCurrent),
        .loopValid     (loopValid),
        .regRdData     (regRdData),
        .tripIrq       (tripIrq),
        .ringCmLevel   (ringCmLevel),
        .ringingActive (ringingActive),
        .currentBoost  (currentBoost)
    );

    // Case equality so that an unknown never passes as a match.
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] expv);
        numChecks++;
        if (seen !== expv)
        begin
            badCount++;
            $display("mismatch %s expected %h seen %h", name, expv, seen);
        end
    endtask

    // Strobes rise and fall on falling edges, so each lasts one rising edge.
    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        @(negedge sys_clk);
        req.addr   = addr;
        req.wrData = data;
        req.wrEn   = 1'b1;
        @(negedge sys_clk);
        req.wrEn   = 1'b0;
    endtask

    task automatic rd(input logic [6:0] addr, output logic [7:0] data);
        @(negedge sys_clk);
        req.addr = addr;
        req.rdEn = 1'b1;
        @(negedge sys_clk);
        req.rdEn = 1'b0;
        data     = regRdData;
    endtask

    task automatic chkReg(input string name, input logic [6:0] addr,
                          input logic [7:0] mask, input logic [7:0] expv);
        logic [7:0] d;
        rd(addr, d);
        check(name, {8'h00, d & mask}, {8'h00, expv});
    endtask

    // Indirect values go low byte, high byte, then the index commits them.
    task automatic wrInd(input logic [7:0] idx, input logic [15:0] v);
        wr(ADDR_IND_DATA_LO, v[7:0]);
        wr(ADDR_IND_DATA_HI, v[15:8]);
        wr(ADDR_IND_WRITE, idx);
    endtask

    task automatic rdInd(input logic [7:0] idx, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        wr(ADDR_IND_READ, idx);
        rd(ADDR_IND_DATA_LO, lo);
        rd(ADDR_IND_DATA_HI, hi);
        v = {hi, lo};
    endtask

    task automatic samples(input logic [7:0] x, input int n);
        repeat (n)
        begin
            @(negedge sys_clk);
            loopCurrent = x;
            loopValid   = 1'b1;
            @(negedge sys_clk);
            loopValid   = 1'b0;
        end
    endtask

    // The write that leaves ringing returns one cycle into any boost.
    task automatic leaveAndCount(input logic [7:0] lf, output int n);
        wr(ADDR_LINEFEED, lf);
        n = (currentBoost === 1'b1) ? 1 : 0;
        repeat (39)
        begin
            @(negedge sys_clk);
            if (currentBoost === 1'b1)
                n++;
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run is a few hundred cycles; this limit only cuts a hang.
    initial
    begin
        repeat (10000) @(posedge sys_clk);
        badCount++;
        $display("mismatch watchdog expired");
        conclude();
    end

    // Main sequence.
    initial
    begin
        repeat (16) @(negedge sys_clk);
        rst_n = 1'b1;
        check("outputs", {6'h00, tripIrq, ringingActive, currentBoost, ringCmLevel}, 16'h0000);
        foreach (rstAddr[i])
            chkReg("reset byte", rstAddr[i], 8'hff, RST_BYTE);
        // Coefficient near full scale lets the filter settle within one sample.
        wrInd(IND_FILT_COEF, 16'h1fff);
        wrInd(IND_THRESHOLD, 16'h3f50);
        wrInd(IND_HEADROOM, 16'h001f);
        rdInd(IND_FILT_COEF, word);
        check("coef", word & 16'h1fff, 16'h1fff);
        rdInd(IND_THRESHOLD, word);
        check("threshold", word & 16'h003f, 16'h0010);
        rdInd(IND_HEADROOM, word);
        check("headroom", word & 16'h000f, 16'h000f);
        rdInd(8'h55, word);
        check("unknown index", word, 16'h0000);
        wr(ADDR_DEBOUNCE, 8'h03);
        chkReg("debounce", ADDR_DEBOUNCE, 8'h7f, 8'h03);
        wr(ADDR_HIGH_BATTERY_LEVEL, 8'h30);
        wr(ADDR_IRQ_EN, 8'h01);
        // Samples outside ringing must not move the detector.
        samples(8'h12, 6);
        chkReg("status idle", ADDR_TRIP_STAT, 8'h01, 8'h00);
        check("cm idle", {9'h000, ringCmLevel}, 16'h0000);
        wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
        // The ringing indication is registered one cycle after the write.
        repeat (2) @(negedge sys_clk);
        check("ringing", {15'h0000, ringingActive}, 16'h0001);
        // Only the low four headroom bits count: 48 - 15 steps.
        check("cm level", {9'h000, ringCmLevel}, 16'h0021);
        // Filter output 0x0f sits just below the 0x10 threshold and must not trip.
        samples(8'h10, 6);
        chkReg("status at threshold", ADDR_TRIP_STAT, 8'h01, 8'h00);
        // First sample compares the old state, then three must not suffice.
        samples(8'h12, 3);
        chkReg("status short", ADDR_TRIP_STAT, 8'h01, 8'h00);
        samples(8'h12, 1);
        chkReg("status trip", ADDR_TRIP_STAT, 8'h01, 8'h01);
        repeat (3) @(negedge sys_clk);
        check("irq", {15'h0000, tripIrq}, 16'h0001);
        chkReg("pending", ADDR_IRQ_PEND, 8'h01, 8'h01);
        wr(ADDR_TRIP_STAT, 8'h00);
        chkReg("status write", ADDR_TRIP_STAT, 8'h01, 8'h01);
        // Off-hook ends: the detector falls but the pending bit must hold.
        samples(8'h00, 8);
        chkReg("status fall", ADDR_TRIP_STAT, 8'h01, 8'h00);
        chkReg("pending held", ADDR_IRQ_PEND, 8'h01, 8'h01);
        check("irq held", {15'h0000, tripIrq}, 16'h0001);
        wr(ADDR_IRQ_PEND, 8'h01);
        chkReg("pending clear", ADDR_IRQ_PEND, 8'h01, 8'h00);
        check("irq clear", {15'h0000, tripIrq}, 16'h0000);
        wr(ADDR_TRIP_STAT, 8'h01);
        chkReg("status write", ADDR_TRIP_STAT, 8'h01, 8'h00);
        // A trip with the enable off sets status but no pending bit.
        wr(ADDR_IRQ_EN, 8'h00);
        samples(8'h12, 6);
        chkReg("status masked", ADDR_TRIP_STAT, 8'h01, 8'h01);
        repeat (3) @(negedge sys_clk);
        chkReg("pending masked", ADDR_IRQ_PEND, 8'h01, 8'h00);
        check("irq masked", {15'h0000, tripIrq}, 16'h0000);
        // Boost on leaving ringing for a dc state lasts exactly its length.
        wr(ADDR_ILIM, 8'h80);
        leaveAndCount(8'h01, boostCnt);
        check("boost len", 16'(boostCnt), 16'(BOOST_SIM));
        check("ringing off", {15'h0000, ringingActive}, 16'h0000);
        chkReg("status cleared", ADDR_TRIP_STAT, 8'h01, 8'h00);
        wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
        leaveAndCount({5'h00, LF_OPEN}, boostCnt);
        check("boost open", 16'(boostCnt), 16'h0000);
        wr(ADDR_ILIM, 8'h00);
        wr(ADDR_LINEFEED, {5'h00, LF_RINGING});
        leaveAndCount(8'h01, boostCnt);
        check("boost off", 16'(boostCnt), 16'h0000);
        conclude();
    end
endmodule
